//--- core/irq_lifecycle.v
// per-interrupt lifecycle engine: banked software and private interrupts per core,
// shared interrupts (wired or message set/clear) and message-held interrupts.
// assumes every input is synchronous to clk and every strobe is one cycle wide;
// the priority logic outside picks which pending interrupt is signalled.
`timescale 1ns/100ps
`default_nettype none
`include "irq_life_consts.vh"

// Functional notes
// - every supported interrupt except message-held ones holds its own four-valued lifecycle state.
// - active-and-pending interrupts are never signalled to a core.
// - message-held interrupts keep only a pending bit, per target core.
// - state changes happen only with distributor and cpu interface enabled.
// - source or software raises pending; inactive to pending, active to active-pending.
// - level source deassert or software clear removes pending.
// - acknowledging a message-held interrupt clears its pending bit.
// - acknowledge of an edge interrupt moves pending to active.
// - acknowledge of a level interrupt moves pending to active-and-pending.
// - deactivate drops active: active to inactive, active-pending to pending.
// - message-held interrupts are edge only and non-secure group 1.
// - private interrupts have per-core group and trigger configuration.
// - extended private range 1056..1119, off in legacy mode, flag reported; the range is not built here and the flag reports it absent.
// - software interrupts are edge; group from which generate register was written.
// - routing picks a target list or all cores except the originator.
// - group-1 generate write yields group 1 of the writer's security state.
// - alias write yields other state; non-secure needs access control permission.
// - group-0 write always from secure, from non-secure only when permitted.
// - extended shared range 4096..5119, off in legacy mode, flag reported; the range is not built here and the flag reports it absent.
// - message set registers make a shared interrupt pending, clear registers clear.
// - edge message-set shared interrupt drops pending on activation or clears.
// - level message-set shared interrupt stays pending until message clear.
// - split mode 0 deactivates on completion; 1 waits for deactivate write.
module irq_lifecycle (
    input  wire                      clk,
    input  wire                      rst,
    // global enables and modes
    input  wire                      dist_enable,
    input  wire                      cpu_if_enable,
    input  wire                      legacy_mode,
    input  wire                      split_completion_mode,
    // wired sources: one line per shared, one per private per core
    input  wire [`NUM_SPI-1:0]       spi_line,
    input  wire [`NUM_CORES*`NUM_PPI-1:0] ppi_line,
    // trigger config (1 = level-sensitive) and per-core private group config
    input  wire [`NUM_SPI-1:0]       spi_level_cfg,
    input  wire [`NUM_CORES*`NUM_PPI-1:0] ppi_level_cfg,
    input  wire [`NUM_CORES*`NUM_PPI*2-1:0] ppi_group_cfg,
    // software pending access to shared interrupts
    input  wire                      set_pending_reg_wr,
    input  wire                      clear_pending_reg_wr,
    input  wire [4:0]                pending_reg_idx,
    // message-based shared set/clear (secure and non-secure forms)
    input  wire                      secure_message_set_reg_wr,
    input  wire                      nonsecure_message_set_reg_wr,
    input  wire                      secure_message_clear_reg_wr,
    input  wire                      nonsecure_message_clear_reg_wr,
    input  wire [`ID_W-1:0]          message_identifier,
    // message-held interrupt arrivals
    input  wire                      lpi_arrive,
    input  wire [0:0]                lpi_core,
    input  wire [3:0]                lpi_index,
    // software generate write
    input  wire                      gen_wr,
    input  wire [1:0]                gen_kind,
    input  wire                      gen_secure,
    input  wire [0:0]                gen_origin,
    input  wire                      gen_route_mode,
    input  wire [`NUM_CORES-1:0]     gen_target_list,
    input  wire [3:0]                gen_identifier,
    input  wire [`NUM_CORES-1:0]     nonsecure_access_control,
    // core acknowledge and completion
    input  wire                      ack_rd,
    input  wire [0:0]                ack_core,
    input  wire [`ID_W-1:0]          ack_identifier,
    input  wire                      completion_wr,
    input  wire                      deactivate_reg_wr,
    input  wire [0:0]                done_core,
    input  wire [`ID_W-1:0]          done_identifier,
    // status outputs
    output reg  [`NUM_SPI*2-1:0]     spi_state_ff,
    output reg  [`NUM_CORES*32*2-1:0] bank_state_ff,
    output reg  [`NUM_CORES*`NUM_LPI-1:0] lpi_pending_ff,
    output reg  [`NUM_CORES*32*2-1:0] sgi_group_ff,
    output reg  [`NUM_CORES-1:0]     signal_ready_ff,
    output reg                       redist_private_range_field,
    output reg                       dist_extended_shared_flag,
    output reg                       dist_message_shared_flag
);

    // returns 1 when a state may be offered to a core
    function signalable;
        input [1:0] st;
        begin
            signalable = (st == `ST_PENDING);
        end
    endfunction

    // shared pending/active step, used for every shared and every banked interrupt
    function [1:0] step;
        input [1:0] st;
        input       raise;
        input       drop;
        input       ack;
        input       level;
        input       deact;
        reg   [1:0] s;
        begin
            s = st;
            if (ack && s == `ST_PENDING) begin
                s = level ? `ST_ACT_PEND : `ST_ACTIVE;
            end
            if (deact) begin
                s = {1'b0, s[0]};
            end
            if (drop) begin
                s = {s[1], 1'b0};
            end
            if (raise) begin
                s = {s[1], 1'b1};
            end
            step = s;
        end
    endfunction

    wire run = dist_enable & cpu_if_enable;
    // a completion deactivates only when split mode is off
    wire deact_go = run & ((completion_wr & ~split_completion_mode) |
                           (deactivate_reg_wr & split_completion_mode));

    // message-set marker per shared interrupt: level ones hold until message clear
    reg  [`NUM_SPI-1:0] msg_set_ff;
    reg  [`NUM_SPI-1:0] spi_line_q_ff;
    wire msg_set = secure_message_set_reg_wr | nonsecure_message_set_reg_wr;
    wire msg_clr = secure_message_clear_reg_wr | nonsecure_message_clear_reg_wr;
    wire [`ID_W-1:0] spi_rel = message_identifier - `SPI_BASE;

    genvar gi;
    generate
        for (gi = 0; gi < `NUM_SPI; gi = gi + 1) begin : g_spi
            wire hit_m = (spi_rel == gi) && (message_identifier >= `SPI_BASE);
            wire m_set = run & msg_set & hit_m;
            wire m_clr = run & msg_clr & hit_m;
            wire p_set = run & set_pending_reg_wr & (pending_reg_idx == gi);
            wire p_clr = run & clear_pending_reg_wr & (pending_reg_idx == gi);
            wire lvl   = spi_level_cfg[gi];
            // wired edge raise on rising line, level follows the line
            wire w_rise = run & spi_line[gi] & ~spi_line_q_ff[gi];
            wire w_fall = run & lvl & ~spi_line[gi] & spi_line_q_ff[gi] & ~msg_set_ff[gi];
            // level message-set ignores the clear-pending write; edge honours it
            wire drop   = m_clr | (p_clr & ~(lvl & msg_set_ff[gi])) | w_fall;
            wire raise  = m_set | p_set | (lvl ? (run & spi_line[gi] & ~m_clr) : w_rise);
            wire ack    = run & ack_rd & (ack_identifier == `SPI_BASE + gi);
            // shared interrupts may be finished from any core
            wire deact  = deact_go & (done_identifier == `SPI_BASE + gi);
            always @(posedge clk) begin
                if (rst) begin
                    spi_state_ff[gi*2+:2] <= `ST_INACTIVE;
                    msg_set_ff[gi]        <= 1'b0;
                    spi_line_q_ff[gi]     <= 1'b0;
                end else begin
                    spi_line_q_ff[gi] <= spi_line[gi];
                    // level message-set stays pending across ack, giving active-pending
                    spi_state_ff[gi*2+:2] <= step(spi_state_ff[gi*2+:2], raise, drop,
                                                  ack, lvl & msg_set_ff[gi] | lvl, deact);
                    if (m_set) begin
                        msg_set_ff[gi] <= 1'b1;
                    end else if (m_clr || (ack && !lvl)) begin
                        msg_set_ff[gi] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // banked software (0..15) and private (16..31) interrupts per core
    reg [`NUM_CORES*`NUM_PPI-1:0] ppi_line_q_ff;
    genvar ci, bi;
    generate
        for (ci = 0; ci < `NUM_CORES; ci = ci + 1) begin : g_core
            // routing: listed cores, or everyone but the writer
            wire targeted = (gen_route_mode == `ROUTE_LIST) ? gen_target_list[ci]
                                                          : (gen_origin != ci);
            wire ns_ok    = nonsecure_access_control[ci];
            // security filter per generate kind
            wire gen_ok   = (gen_kind == `GEN_G1) |
                            ((gen_kind == `GEN_ALIAS) & (gen_secure | ns_ok)) |
                            ((gen_kind == `GEN_G0) & (gen_secure | ns_ok));
            wire [1:0] gen_grp = (gen_kind == `GEN_G0) ? `GRP_0 :
                                 ((gen_kind == `GEN_G1) ^ ~gen_secure) ? `GRP_S1 : `GRP_NS1;
            for (bi = 0; bi < 32; bi = bi + 1) begin : g_bank
                // software slots clamp to the core's first private index; is_ppi masks them
                localparam integer PI = ci * `NUM_PPI + ((bi >= 16) ? (bi - 16) : 0);
                wire is_ppi = (bi >= 16);
                wire sgi_raise = run & gen_wr & targeted & gen_ok &
                                 (gen_identifier == bi) & ~is_ppi;
                wire lvl  = is_ppi ? ppi_level_cfg[PI] : 1'b0;
                wire line = is_ppi ? ppi_line[PI] : 1'b0;
                wire lq   = is_ppi ? ppi_line_q_ff[PI] : 1'b0;
                wire raise = sgi_raise | (run & line & (lvl | ~lq));
                wire drop  = run & lvl & ~line & lq;
                wire ack   = run & ack_rd & (ack_core == ci) & (ack_identifier == bi);
                // banked interrupts are finished by the activating core only
                wire deact = deact_go & (done_core == ci) & (done_identifier == bi);
                always @(posedge clk) begin
                    if (rst) begin
                        bank_state_ff[(ci*32+bi)*2+:2] <= `ST_INACTIVE;
                        sgi_group_ff[(ci*32+bi)*2+:2]  <= `GRP_0;
                    end else begin
                        bank_state_ff[(ci*32+bi)*2+:2] <=
                            step(bank_state_ff[(ci*32+bi)*2+:2], raise, drop, ack, lvl, deact);
                        if (sgi_raise) begin
                            sgi_group_ff[(ci*32+bi)*2+:2] <= gen_grp;
                        end else if (is_ppi) begin
                            sgi_group_ff[(ci*32+bi)*2+:2] <= ppi_group_cfg[PI*2+:2];
                        end
                    end
                end
            end

            // message-held: pending bit only, edge only, no active state
            genvar li;
            for (li = 0; li < `NUM_LPI; li = li + 1) begin : g_lpi
                wire arr = run & lpi_arrive & (lpi_core == ci) & (lpi_index == li);
                wire ack = run & ack_rd & (ack_core == ci) &
                           (ack_identifier == `LPI_BASE + li);
                always @(posedge clk) begin
                    if (rst) begin
                        lpi_pending_ff[ci*`NUM_LPI+li] <= 1'b0;
                    end else if (arr) begin
                        lpi_pending_ff[ci*`NUM_LPI+li] <= 1'b1; // arrival wins
                    end else if (ack) begin
                        lpi_pending_ff[ci*`NUM_LPI+li] <= 1'b0;
                    end
                end
            end

            // any signalable banked or shared interrupt, or pending message-held one, wakes this core
            reg any_c;
            integer k;
            always @* begin
                any_c = 1'b0;
                for (k = 0; k < 32; k = k + 1) begin
                    any_c = any_c | signalable(bank_state_ff[(ci*32+k)*2+:2]);
                end
                for (k = 0; k < `NUM_SPI; k = k + 1) begin
                    any_c = any_c | signalable(spi_state_ff[k*2+:2]);
                end
                any_c = any_c | (|lpi_pending_ff[ci*`NUM_LPI+:`NUM_LPI]);
            end
            always @(posedge clk) begin
                if (rst) begin
                    signal_ready_ff[ci] <= 1'b0;
                end else begin
                    signal_ready_ff[ci] <= run & any_c;
                end
            end
        end
    endgenerate

    // line history and reported capability flags
    always @(posedge clk) begin
        if (rst) begin
            ppi_line_q_ff              <= {`NUM_CORES*`NUM_PPI{1'b0}};
            redist_private_range_field <= `RST_FLAG;
            dist_extended_shared_flag  <= `RST_FLAG;
            dist_message_shared_flag   <= `RST_FLAG;
        end else begin
            ppi_line_q_ff <= ppi_line;
            // extended ranges are not built here, so report them absent;
            // legacy mode would hide them anyway
            redist_private_range_field <= 1'b0 & ~legacy_mode;
            dist_extended_shared_flag  <= 1'b0 & ~legacy_mode;
            dist_message_shared_flag   <= 1'b1;
        end
    end

endmodule
`default_nettype wire

//--- core/irq_life_consts.vh
// constants for the interrupt lifecycle block
// assumes inclusion by bare name from core/ design files
`ifndef IRQ_LIFE_CONSTS_VH
`define IRQ_LIFE_CONSTS_VH
// lifecycle state encoding
`define ST_INACTIVE     2'h0
`define ST_PENDING      2'h1
`define ST_ACTIVE       2'h2
`define ST_ACT_PEND     2'h3
// population of interrupts held here, plus the extended ranges that are not built
`define NUM_CORES       2
`define NUM_SGI         16
`define NUM_PPI         16
`define NUM_SPI         32
`define NUM_LPI         16
`define NUM_EPPI        64
`define NUM_ESPI        1024
// identifier map
`define ID_W            13
`define SGI_BASE        13'h0000
`define PPI_BASE        13'h0010
`define SPI_BASE        13'h0020
`define EPPI_BASE       13'h0420
`define EPPI_LAST       13'h045f
`define ESPI_BASE       13'h1000
`define ESPI_LAST       13'h13ff
`define LPI_BASE        13'h1fe0
// group encodings
`define GRP_0           2'h0
`define GRP_S1          2'h1
`define GRP_NS1         2'h2
// generate-write kinds
`define GEN_G1          2'h0
`define GEN_ALIAS       2'h1
`define GEN_G0          2'h2
// routing mode: 0 = target list, 1 = all but originator
`define ROUTE_LIST      1'b0
`define ROUTE_OTHERS    1'b1
// reset values of type flags
`define RST_FLAG        1'b0
`endif

//--- sim/irq_life_checker.sv
// checker for the lifecycle block: core 0 software id 3, message-held bits, flags
// assumes a bind onto irq_lifecycle with every port matched by name
`timescale 1ns/100ps
`default_nettype none
`include "irq_life_consts.vh"
module irq_life_checker (
    input wire logic         clk,
    input wire logic         rst,
    input wire logic         dist_enable,
    input wire logic         cpu_if_enable,
    input wire logic         split_completion_mode,
    input wire logic         gen_wr,
    input wire logic [1:0]   gen_kind,
    input wire logic         gen_secure,
    input wire logic         gen_route_mode,
    input wire logic [1:0]   gen_target_list,
    input wire logic [3:0]   gen_identifier,
    input wire logic [1:0]   nonsecure_access_control,
    input wire logic         ack_rd,
    input wire logic [0:0]   ack_core,
    input wire logic [12:0]  ack_identifier,
    input wire logic         completion_wr,
    input wire logic         deactivate_reg_wr,
    input wire logic [0:0]   done_core,
    input wire logic [12:0]  done_identifier,
    input wire logic         lpi_arrive,
    input wire logic [127:0] bank_state_ff,
    input wire logic [31:0]  lpi_pending_ff,
    input wire logic [127:0] sgi_group_ff,
    input wire logic         redist_private_range_field,
    input wire logic         dist_extended_shared_flag
);
    // only the watched software interrupt is decoded, to keep antecedents exact
    wire logic       en = dist_enable && cpu_if_enable;
    wire logic [1:0] s3 = bank_state_ff[7:6];
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_q; en && !gen_wr; endsequence
    sequence s_g1;
        en && gen_wr && gen_kind == `GEN_G1 && gen_route_mode == `ROUTE_LIST
            && gen_target_list[0] && gen_identifier == 4'h3;
    endsequence
    property p_reset; disable iff (1'b0) rst |=> bank_state_ff == 128'h0 && lpi_pending_ff == 32'h0; endproperty
    a_reset: assert property (p_reset) else $error("state not cleared by reset");
    property p_hold; !en |=> $stable(bank_state_ff) && $stable(lpi_pending_ff); endproperty
    a_hold: assert property (p_hold) else $error("state moved while disabled");
    property p_raise; s_g1 ##0 s3 == `ST_INACTIVE |=> s3 == `ST_PENDING; endproperty
    a_raise: assert property (p_raise) else $error("generate did not raise");
    property p_group; s_g1 ##0 gen_secure && s3 == `ST_INACTIVE |=> sgi_group_ff[7:6] == `GRP_S1; endproperty
    a_group: assert property (p_group) else $error("wrong software group");
    property p_g0_ns;
        en && gen_wr && gen_kind == `GEN_G0 && !gen_secure && !nonsecure_access_control[0]
            && gen_route_mode == `ROUTE_LIST && gen_target_list[0] && gen_identifier == 4'h3
            && s3 == `ST_INACTIVE |=> s3 == `ST_INACTIVE;
    endproperty
    a_g0_ns: assert property (p_g0_ns) else $error("refused generate took effect");
    property p_ack;
        s_q ##0 ack_rd && ack_core == 1'b0 && ack_identifier == 13'h3 && s3 == `ST_PENDING
            && !completion_wr && !deactivate_reg_wr |=> s3 == `ST_ACTIVE;
    endproperty
    a_ack: assert property (p_ack) else $error("edge ack not active");
    property p_done;
        s_q ##0 completion_wr && !split_completion_mode && done_core == 1'b0
            && done_identifier == 13'h3 && s3[1] |=> s3 == {1'b0, $past(s3[0])};
    endproperty
    a_done: assert property (p_done) else $error("completion did not deactivate");
    property p_split;
        s_q ##0 completion_wr && split_completion_mode && !deactivate_reg_wr
            && s3 == `ST_ACTIVE |=> s3 == `ST_ACTIVE;
    endproperty
    a_split: assert property (p_split) else $error("split completion deactivated");
    property p_lpi; en && ack_rd && ack_core == 1'b0 && ack_identifier == `LPI_BASE && !lpi_arrive |=> !lpi_pending_ff[0]; endproperty
    a_lpi: assert property (p_lpi) else $error("message-held ack kept pending");
    property p_ext; !dist_extended_shared_flag && !redist_private_range_field; endproperty
    a_ext: assert property (p_ext) else $error("extended range flag set");
endmodule
`default_nettype wire

//--- sim/line_src.sv
// wired interrupt source model: 32 shared lines, then 16 private lines per core
// assumes one-cycle fire/drop strobes synchronous to clk; lines move one edge later
`timescale 1ns/100ps
`default_nettype none
module line_src (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       fire,
    input  wire logic       drop,
    input  wire logic [5:0] idx,
    output var  logic [63:0] lines
);
    // a level source holds its line until told to let go; letting go is what
    // removes pending on the device side, so it is never done early
    always @(posedge clk) begin
        if (rst) begin
            lines <= 64'h0;
        end else if (fire) begin
            lines[idx] <= 1'b1;
        end else if (drop) begin
            lines[idx] <= 1'b0;
        end
    end
endmodule
`default_nettype wire

//--- sim/tb_top.sv
// self-checking bench for the lifecycle block with the wired source model
// assumes core/ on the include path; strobes are one cycle wide from rising edges
`timescale 1ns/100ps
`default_nettype none
`include "irq_life_consts.vh"
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin error_cnt++; \
    $display("FAIL %s expected %h seen %h", nm, ex, got); end end
module tb_top;
    logic clk = 0, rst = 1, dist_enable = 0, cpu_if_enable = 0, legacy_mode = 0;
    logic split_completion_mode = 0, set_pending_reg_wr = 0, clear_pending_reg_wr = 0;
    logic secure_message_set_reg_wr = 0, nonsecure_message_set_reg_wr = 0;
    logic secure_message_clear_reg_wr = 0, nonsecure_message_clear_reg_wr = 0;
    logic lpi_arrive = 0, gen_wr = 0, gen_secure = 0, gen_route_mode = 0, ack_rd = 0;
    logic completion_wr = 0, deactivate_reg_wr = 0, fire = 0, drop = 0;
    logic [0:0] lpi_core = 0, gen_origin = 0, ack_core = 0, done_core = 0;
    logic [1:0] gen_kind = 0, gen_target_list = 0, nonsecure_access_control = 0;
    logic [3:0] lpi_index = 0, gen_identifier = 0;
    logic [4:0] pending_reg_idx = 0;
    logic [5:0] idx = 0;
    logic [12:0] message_identifier = 0, ack_identifier = 0, done_identifier = 0;
    logic [31:0] spi_level_cfg = 0, ppi_level_cfg = 0, lpi_pending_ff;
    logic [63:0] ppi_group_cfg = 0, spi_state_ff, lines;
    logic [127:0] bank_state_ff, sgi_group_ff;
    logic [1:0] signal_ready_ff;
    logic redist_private_range_field, dist_extended_shared_flag, dist_message_shared_flag;
    wire logic [31:0] spi_line = lines[31:0];
    wire logic [31:0] ppi_line = lines[63:32];
    int error_cnt = 0, n_checks = 0, cyc = 0;
    // generate rows: kind, secure writer, permit, pending expected, group expected
    localparam logic [13:0] TK = 14'h185a, TG = 14'h0290;
    localparam logic [6:0] TS = 7'h28, PM = 7'h06, TP = 7'h3e;
    irq_lifecycle dut (.*);
    line_src src (.clk, .rst, .fire, .drop, .idx, .lines);
    always #4 clk = ~clk;
    function automatic logic [1:0] bs(input int c, input int id);
        return bank_state_ff[(c * 32 + id) * 2 +: 2];
    endfunction
    function automatic logic [1:0] ss(input int n);
        return spi_state_ff[n * 2 +: 2];
    endfunction
    task close_out;
        if (error_cnt == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // the sequence needs about a hundred cycles; this ceiling only catches a hang
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            close_out();
        end
    end
    // strobes are sampled once, then dropped; results are read at the falling edge
    task fin;
        @(posedge clk);
        {gen_wr, ack_rd, completion_wr, deactivate_reg_wr, lpi_arrive, fire, drop} <= 7'h0;
        {set_pending_reg_wr, clear_pending_reg_wr, secure_message_set_reg_wr} <= 3'h0;
        {nonsecure_message_set_reg_wr, secure_message_clear_reg_wr} <= 2'h0;
        nonsecure_message_clear_reg_wr <= 1'b0;
        @(negedge clk);
    endtask
    task gen(input logic [1:0] k, input logic s, m, input logic [1:0] l, input logic [3:0] id);
        @(posedge clk);
        {gen_wr, gen_kind, gen_secure, gen_route_mode, gen_target_list, gen_identifier}
            <= {1'b1, k, s, m, l, id};
        fin;
    endtask
    task ack(input logic [0:0] c, input logic [12:0] id);
        @(posedge clk);
        {ack_rd, ack_core, ack_identifier} <= {1'b1, c, id};
        fin;
    endtask
    // dr picks the deactivate write, otherwise a completion write
    task done(input logic dr, input logic [0:0] c, input logic [12:0] id);
        @(posedge clk);
        {completion_wr, deactivate_reg_wr, done_core, done_identifier} <= {!dr, dr, c, id};
        fin;
    endtask
    // op: 0 non-secure set, 1 secure set, 2 non-secure clear, 3 secure clear
    task msg(input int op, input logic [12:0] id);
        @(posedge clk);
        message_identifier <= id;
        {secure_message_clear_reg_wr, nonsecure_message_clear_reg_wr,
            secure_message_set_reg_wr, nonsecure_message_set_reg_wr} <= 4'h1 << op;
        fin;
    endtask
    task pend(input logic clr, input logic [4:0] i);
        @(posedge clk);
        {clear_pending_reg_wr, set_pending_reg_wr, pending_reg_idx} <= {clr, !clr, i};
        fin;
    endtask
    // the line moves one edge after the strobe, the device reacts one edge later
    task srcl(input logic f, input logic [5:0] i);
        @(posedge clk);
        {fire, drop, idx} <= {f, !f, i};
        fin;
        @(negedge clk);
    endtask
    task memory_held_message_interrupt(input logic [0:0] c, input logic [3:0] i);
        @(posedge clk);
        {lpi_arrive, lpi_core, lpi_index} <= {1'b1, c, i};
        fin;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(negedge clk);
        `CHK("bank reset", 128'h0, bank_state_ff)
        `CHK("spi reset", 64'h0, spi_state_ff)
        `CHK("ext flags", 2'h0, {dist_extended_shared_flag, redist_private_range_field})
        `CHK("msg flag", 1'b1, dist_message_shared_flag)
        gen(`GEN_G1, 1'b1, `ROUTE_LIST, 2'h1, 4'h3);
        `CHK("gen disabled", `ST_INACTIVE, bs(0, 3))
        @(posedge clk) {dist_enable, cpu_if_enable} <= 2'h3;
        gen(`GEN_G1, 1'b1, `ROUTE_LIST, 2'h1, 4'h3);
        `CHK("sgi raised", `ST_PENDING, bs(0, 3))
        `CHK("sgi untargeted", `ST_INACTIVE, bs(1, 3))
        `CHK("sgi group", `GRP_S1, sgi_group_ff[7:6])
        @(negedge clk) `CHK("ready pending", 2'h1, signal_ready_ff)
        ack(1'b0, 13'h3);
        `CHK("sgi acked", `ST_ACTIVE, bs(0, 3))
        gen(`GEN_G1, 1'b1, `ROUTE_LIST, 2'h1, 4'h3);
        `CHK("sgi again", `ST_ACT_PEND, bs(0, 3))
        @(negedge clk) `CHK("ready act pend", 2'h0, signal_ready_ff)
        done(1'b0, 1'b0, 13'h3);
        `CHK("completion", `ST_PENDING, bs(0, 3))
        ack(1'b0, 13'h3);
        @(posedge clk) split_completion_mode <= 1'b1;
        done(1'b0, 1'b0, 13'h3);
        `CHK("split completion", `ST_ACTIVE, bs(0, 3))
        done(1'b1, 1'b1, 13'h3);
        `CHK("foreign deactivate", `ST_ACTIVE, bs(0, 3))
        done(1'b1, 1'b0, 13'h3);
        `CHK("deactivate", `ST_INACTIVE, bs(0, 3))
        gen(`GEN_G0, 1'b0, `ROUTE_LIST, 2'h1, 4'h3);
        `CHK("g0 refused", `ST_INACTIVE, bs(0, 3))
        gen(`GEN_G1, 1'b0, `ROUTE_OTHERS, 2'h3, 4'h5);
        `CHK("others target", `ST_PENDING, bs(1, 5))
        `CHK("others origin", `ST_INACTIVE, bs(0, 5))
        for (int i = 0; i < 7; i++) begin
            @(posedge clk) nonsecure_access_control <= {PM[i], 1'b0};
            gen(TK[i * 2 +: 2], TS[i], `ROUTE_LIST, 2'h2, 4'(6 + i));
            `CHK("sgi security", TP[i] ? `ST_PENDING : `ST_INACTIVE, bs(1, 6 + i))
            if (TP[i])
                `CHK("sgi grp", TG[i * 2 +: 2], sgi_group_ff[(38 + i) * 2 +: 2])
        end
        @(posedge clk) spi_level_cfg <= 32'h5; // changed only while no shared interrupt is pending
        srcl(1'b1, 6'd0);
        `CHK("level raised", `ST_PENDING, ss(0))
        ack(1'b0, 13'h20);
        `CHK("level acked", `ST_ACT_PEND, ss(0))
        srcl(1'b0, 6'd0);
        `CHK("level released", `ST_ACTIVE, ss(0))
        done(1'b1, 1'b1, 13'h20);
        `CHK("spi deactivated", `ST_INACTIVE, ss(0))
        msg(0, 13'h21);
        `CHK("msg set", `ST_PENDING, ss(1))
        pend(1'b1, 5'd1);
        `CHK("msg edge clear", `ST_INACTIVE, ss(1))
        msg(1, 13'h21);
        ack(1'b0, 13'h21);
        `CHK("msg edge acked", `ST_ACTIVE, ss(1))
        msg(1, 13'h21);
        msg(3, 13'h21);
        `CHK("msg secure clear", `ST_ACTIVE, ss(1))
        msg(0, 13'h22);
        ack(1'b1, 13'h22);
        `CHK("msg level acked", `ST_ACT_PEND, ss(2))
        msg(2, 13'h22);
        `CHK("msg level clear", `ST_ACTIVE, ss(2))
        pend(1'b0, 5'd3);
        `CHK("set pending", `ST_PENDING, ss(3))
        pend(1'b1, 5'd3);
        `CHK("clear pending", `ST_INACTIVE, ss(3))
        srcl(1'b1, 6'd32);
        `CHK("ppi core0", `ST_PENDING, bs(0, 16))
        `CHK("ppi core1", `ST_INACTIVE, bs(1, 16))
        memory_held_message_interrupt(1'b0, 4'h0);
        memory_held_message_interrupt(1'b1, 4'h2);
        `CHK("lpi arrive", 32'h0004_0001, lpi_pending_ff)
        ack(1'b0, `LPI_BASE);
        ack(1'b1, `LPI_BASE + 13'h2);
        `CHK("lpi acked", 32'h0, lpi_pending_ff)
        @(posedge clk) rst <= 1'b1;
        @(posedge clk) rst <= 1'b0;
        @(negedge clk);
        `CHK("bank second reset", 128'h0, bank_state_ff)
        `CHK("spi second reset", 64'h0, spi_state_ff)
        close_out();
    end
endmodule
bind irq_lifecycle irq_life_checker chk (.*);
`default_nettype wire
